// [synth_loop_control_logic.v]
// top of the synthesizer loop control logic
`timescale 1ns/1ns
`default_nettype none
`include "synth_ctrl_consts.vh"
module synth_loop_control_logic (
  input wire clk_sys,
  input wire rst,
  input wire main_loop_enable,
  input wire aux_loop_enable,
  input wire alternate_programming_scheme,
  input wire [3:0] speedup_length,
  input wire main_word_load,
  input wire load_strobe,
  input wire ref_div_pulse,
  input wire test_word_load,
  input wire [19:0] test_word,
  input wire fourth_word_load,
  input wire main_lock_flag,
  input wire aux_lock_flag,
  input wire if_lock_flag,
  input wire transmit_enable,
  input wire standby_mode,
  input wire [1:0] if_div_code,
  input wire frac_overflow,
  input wire aux_div_out,
  input wire main_div_out,
  input wire main_ref_div_out,
  output reg main_stage_on,
  output reg aux_stage_on,
  output reg ref_chain_on,
  output reg word_load_ready,
  output reg speedup_on,
  output reg integral_pump_on,
  output reg lock_out,
  output reg pump_force_up,
  output reg pump_force_down,
  output reg ref_chain_test,
  output reg main_prescaler_bypass,
  output reg aux_prescaler_bypass,
  output reg frac_pump_test,
  output reg if_synth_on,
  output reg tx_chain_on,
  output reg [3:0] if_divide_ratio,
  output reg free_clock_on,
  output reg switched_clock_on
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // IF feedback divide ratio from its two-bit code
  function [3:0] div_ratio;
    input [1:0] code;
    begin
      div_ratio = `IF_DIV_BASE + {2'b00, code};
    end
  endfunction

  // lock term of one loop: locked, or switched off by its enable
  function loop_term;
    input locked;
    input enabled;
    begin
      loop_term = locked | ~enabled;
    end
  endfunction

  // low nibble of a test word holds the given code
  function nibble_is;
    input [19:0] word;
    input [3:0] code;
    begin
      nibble_is = (word[3:0] == code);
    end
  endfunction

  // only the top nibble of a test word is set, to the given code
  function top_only;
    input [19:0] word;
    input [3:0] code;
    begin
      top_only = (word[19:16] == code) && (word[15:0] == 16'h0000);
    end
  endfunction

  // low byte holds the given code and every bit above it is zero
  function low_byte_only;
    input [19:0] word;
    input [7:0] code;
    begin
      low_byte_only = (word[19:8] == 12'h000) && (word[7:0] == code);
    end
  endfunction

  reg [19:0] test_reg;
  reg lock_next;
  reg route_next;
  reg route_hit;
  wire speedup_w;
  wire synth_w;
  wire txchain_w;
  wire main_term;
  wire aux_term;
  wire if_term;
  wire test_plain;
  wire test_force_hi;
  wire test_force_lo;
  wire test_pump_up;
  wire test_pump_down;
  wire test_ref_chain;
  wire test_main_bypass;
  wire test_aux_bypass;
  wire test_frac_pump;

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  speedup_timer u_speedup (
    .clk_sys(clk_sys),
    .rst(rst),
    .alternate_programming_scheme(alternate_programming_scheme),
    .speedup_length(speedup_length),
    .main_word_load(main_word_load),
    .load_strobe(load_strobe),
    .ref_div_pulse(ref_div_pulse),
    .speedup_active(speedup_w)
  );

  if_synth_sequencer u_seq (
    .clk_sys(clk_sys),
    .rst(rst),
    .load_strobe(load_strobe),
    .transmit_enable(transmit_enable),
    .if_synth_on(synth_w),
    .tx_chain_on(txchain_w)
  );

  // ----------------------------------------------------------------
  // test word register
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      test_reg <= `TEST_ZERO;
    end else if (fourth_word_load) begin
      test_reg <= `TEST_ZERO;
    end else if (test_word_load) begin
      test_reg <= test_word;
    end
  end

  // ----------------------------------------------------------------
  // lock pin
  // ----------------------------------------------------------------
  // a loop that is switched off never holds the pin low
  assign main_term = loop_term(main_lock_flag, main_loop_enable);
  assign aux_term = loop_term(aux_lock_flag, aux_loop_enable);
  // if loop counts as disabled when its enable flop is low
  assign if_term = loop_term(if_lock_flag, synth_w) |
    standby_mode;

  // ----------------------------------------------------------------
  // test word decode
  // ----------------------------------------------------------------
  // a fourth word or a zero word clears every mode below
  assign test_plain = (test_reg[19:4] == 16'h0000);
  assign test_force_hi = top_only(test_reg, `TEST_FORCE_HI);
  assign test_force_lo = top_only(test_reg, `TEST_FORCE_LO);
  assign test_pump_up = low_byte_only(test_reg, `TEST_PUMP_UP);
  assign test_pump_down =
    low_byte_only(test_reg, `TEST_PUMP_DOWN);
  assign test_ref_chain = (test_reg[19:16] == `TEST_REF_CHAIN) &&
    nibble_is(test_reg, `TEST_SEL_REFDIV);
  assign test_main_bypass = (test_reg[11:8] == `TEST_PRE_BYPASS) &&
    nibble_is(test_reg, `TEST_SEL_MAINDIV);
  assign test_aux_bypass = test_reg[15] &&
    nibble_is(test_reg, `TEST_SEL_AUXDIV);
  assign test_frac_pump = (test_reg[11:8] == `TEST_FRAC_PUMP);

  // ----------------------------------------------------------------
  // lock pin
  // ----------------------------------------------------------------
  // node picked by the low nibble; the overflow node only on a plain word
  always @* begin
    route_next = 1'b0;
    route_hit = 1'b1;
    if (nibble_is(test_reg, `TEST_SEL_AUXDIV)) begin
      route_next = aux_div_out;
    end else if (nibble_is(test_reg, `TEST_SEL_MAINDIV)) begin
      route_next = main_div_out;
    end else if (nibble_is(test_reg, `TEST_SEL_REFDIV)) begin
      route_next = main_ref_div_out;
    end else if (test_plain && nibble_is(test_reg, `TEST_SEL_FRAC)) begin
      route_next = frac_overflow;
    end else begin
      route_hit = 1'b0;
    end
  end

  always @* begin
    lock_next = main_term & aux_term & if_term;
    if (test_force_hi) begin
      lock_next = 1'b1;
    end else if (test_force_lo) begin
      lock_next = 1'b0;
    end else if (route_hit) begin
      lock_next = route_next;
    end
  end

  // ----------------------------------------------------------------
  // loop power gating
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      main_stage_on <= 1'b0;
      aux_stage_on <= 1'b0;
      ref_chain_on <= 1'b0;
      word_load_ready <= 1'b0;
    end else begin
      main_stage_on <= main_loop_enable;
      aux_stage_on <= aux_loop_enable;
      ref_chain_on <= main_loop_enable | aux_loop_enable;
      // word loading never waits on the reference chain
      word_load_ready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // speed-up currents
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      speedup_on <= 1'b0;
      integral_pump_on <= 1'b0;
    end else begin
      // currents follow the timer only while the main loop is powered
      speedup_on <= speedup_w & main_loop_enable;
      integral_pump_on <= speedup_w & main_loop_enable;
    end
  end

  // ----------------------------------------------------------------
  // lock pin register
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_out <= 1'b0;
    end else begin
      lock_out <= lock_next;
    end
  end

  // ----------------------------------------------------------------
  // test mode outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pump_force_up <= 1'b0;
      pump_force_down <= 1'b0;
      ref_chain_test <= 1'b0;
      main_prescaler_bypass <= 1'b0;
      aux_prescaler_bypass <= 1'b0;
      frac_pump_test <= 1'b0;
    end else begin
      // each mode holds only while its test word stays loaded
      pump_force_up <= test_pump_up;
      pump_force_down <= test_pump_down;
      ref_chain_test <= test_ref_chain;
      main_prescaler_bypass <= test_main_bypass;
      aux_prescaler_bypass <= test_aux_bypass;
      frac_pump_test <= test_frac_pump;
    end
  end

  // ----------------------------------------------------------------
  // IF chain
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      if_synth_on <= 1'b0;
      tx_chain_on <= 1'b0;
      if_divide_ratio <= `IF_DIV_BASE;
    end else begin
      // transmit path needs both the synth flop and transmit enable
      if_synth_on <= synth_w;
      tx_chain_on <= txchain_w;
      if_divide_ratio <= div_ratio(if_div_code);
    end
  end

  // ----------------------------------------------------------------
  // clock outputs
  // ----------------------------------------------------------------
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      free_clock_on <= 1'b0;
      switched_clock_on <= 1'b0;
    end else begin
      free_clock_on <= 1'b1;
      // switched clock serves circuits used in standby or transmit only
      switched_clock_on <= standby_mode | transmit_enable;
    end
  end
endmodule // synth_loop_control_logic
`default_nettype wire

// [synth_ctrl_consts.vh]
// constants for the synthesizer loop control logic
//
// Behaviour
// - each loop enabled only by its own bit
// - disabled loop gates input stage and pump bias
// - reference chain off only when both loops off
// - word loading works with reference chain down
// - speed-up raises proportional, enables integral pump
// - alternate scheme: speed-up lasts 16 times length plus 15 reference periods
// - count is length nibble over four ones
// - standard scheme: speed-up while load strobe active
// - lock is AND of per-loop lock-or-disabled
// - test word with low nibble 5 to 7, or plain word with 4, routes node to lock pin
// - zero test word or fourth word clears test
// - low nibble selects lock pin source
// - pump source and sink test codes
// - reference test, prescaler bypass, fractional pump test
// - strobe falling edge sets synth enable flop
// - transmit enable rise leaves synth enable alone
// - transmit enable fall clears synth enable
// - standby forces IF lock term true
// - two-bit field gives divide ratio 6 to 9
// - free clock always on, switched clock gated
`ifndef SYNTH_CTRL_CONSTS_VH
`define SYNTH_CTRL_CONSTS_VH
`define TEST_W 20
`define TEST_ZERO 20'h00000
`define TEST_SEL_LOCK 4'h0
`define TEST_SEL_FRAC 4'h4
`define TEST_SEL_AUXDIV 4'h5
`define TEST_SEL_MAINDIV 4'h6
`define TEST_SEL_REFDIV 4'h7
`define TEST_PUMP_UP 8'hA8
`define TEST_PUMP_DOWN 8'h58
`define TEST_FRAC_PUMP 4'h2
`define TEST_PRE_BYPASS 4'h1
`define TEST_REF_CHAIN 4'h1
`define TEST_FORCE_HI 4'hC
`define TEST_FORCE_LO 4'h4
`define SPEEDUP_LOW_ONES 4'hF
`define IF_DIV_BASE 4'h6
`endif

// [speedup_timer.v]
// speed-up duration timer for both programming schemes
`timescale 1ns/1ns
`default_nettype none
`include "synth_ctrl_consts.vh"
module speedup_timer (
  input wire clk_sys,
  input wire rst,
  input wire alternate_programming_scheme,
  input wire [3:0] speedup_length,
  input wire main_word_load,
  input wire load_strobe,
  input wire ref_div_pulse,
  output wire speedup_active
);
  reg [7:0] count_reg;
  reg [7:0] count_next;

  always @* begin
    count_next = count_reg;
    if (main_word_load) begin
      count_next = {speedup_length, `SPEEDUP_LOW_ONES};
    end else if (ref_div_pulse && count_reg != 8'h00) begin
      count_next = count_reg - 8'h01;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= 8'h00;
    end else begin
      count_reg <= count_next;
    end
  end

  // standard scheme follows the strobe level directly
  assign speedup_active = alternate_programming_scheme ?
    (count_reg != 8'h00) : load_strobe;
endmodule // speedup_timer
`default_nettype wire

// [if_synth_sequencer.v]
// IF synthesizer enable sequencer driven by strobe and transmit enable
`timescale 1ns/1ns
`default_nettype none
`include "synth_ctrl_consts.vh"
module if_synth_sequencer (
  input wire clk_sys,
  input wire rst,
  input wire load_strobe,
  input wire transmit_enable,
  output wire if_synth_on,
  output wire tx_chain_on
);
  reg strobe_d_reg;
  reg tx_enable_d_reg;
  reg synth_reg;
  reg clear_reg;
  wire strobe_fall;
  wire tx_enable_fall;

  assign strobe_fall = strobe_d_reg & ~load_strobe;
  assign tx_enable_fall = tx_enable_d_reg & ~transmit_enable;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strobe_d_reg <= 1'b0;
      tx_enable_d_reg <= 1'b0;
      synth_reg <= 1'b0;
      clear_reg <= 1'b0;
    end else begin
      strobe_d_reg <= load_strobe;
      tx_enable_d_reg <= transmit_enable;
      clear_reg <= tx_enable_fall;
      // a new strobe fall wins over a pending clear
      if (strobe_fall) begin
        synth_reg <= 1'b1;
      end else if (clear_reg) begin
        synth_reg <= 1'b0;
      end
    end
  end

  assign if_synth_on = synth_reg;
  assign tx_chain_on = synth_reg & transmit_enable;
endmodule // if_synth_sequencer
`default_nettype wire

// [synth_ctrl_asserts.sv]
// checker for the synthesizer loop control outputs
`timescale 1ns/1ns
`default_nettype none
module synth_ctrl_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic main_loop_enable,
  input wire logic aux_loop_enable,
  input wire logic alternate_programming_scheme,
  input wire logic load_strobe,
  input wire logic transmit_enable,
  input wire logic standby_mode,
  input wire logic [1:0] if_div_code,
  input wire logic main_stage_on,
  input wire logic aux_stage_on,
  input wire logic ref_chain_on,
  input wire logic speedup_on,
  input wire logic integral_pump_on,
  input wire logic if_synth_on,
  input wire logic [3:0] if_divide_ratio,
  input wire logic free_clock_on,
  input wire logic switched_clock_on
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  main_gate_a: assert property (main_loop_enable |=> main_stage_on)
    else $error("main stage not on");
  aux_gate_a: assert property (!aux_loop_enable |=> !aux_stage_on)
    else $error("aux stage not off");
  ref_off_a: assert property (!main_loop_enable && !aux_loop_enable
    |=> !ref_chain_on) else $error("reference chain left on");
  ref_on_a: assert property (main_loop_enable || aux_loop_enable
    |=> ref_chain_on) else $error("reference chain off");
  standard_speed_a: assert property (
    !alternate_programming_scheme && main_loop_enable && load_strobe
    |=> speedup_on) else $error("speed-up missing under strobe");
  pump_pair_a: assert property (integral_pump_on == speedup_on)
    else $error("integral pump out of step");
  synth_set_a: assert property ($fell(load_strobe) |-> ##2
    if_synth_on) else $error("synth enable not set");
  tx_hold_a: assert property ($rose(transmit_enable) && if_synth_on
    |=> if_synth_on) else $error("synth enable dropped on rise");
  synth_clr_a: assert property ($fell(transmit_enable) ##0
    !load_strobe [*3] |=> !if_synth_on) else $error("synth not cleared");
  div_map_a: assert property (!$past(rst) |->
    if_divide_ratio == 4'h6 + $past(if_div_code)) else $error("bad ratio");
  clk_gate_a: assert property (!$past(rst) |-> free_clock_on &&
    switched_clock_on == $past(standby_mode || transmit_enable))
    else $error("clock output gating wrong");
  cover property (alternate_programming_scheme && $fell(speedup_on));
  cover property ($rose(if_synth_on));
  cover property ($fell(if_synth_on));
endmodule // synth_ctrl_checker
bind synth_loop_control_logic synth_ctrl_checker chk (.*);
`default_nettype wire

// [bb_ctrl_model.sv]
// baseband controller model: strobe pulse, then transmit burst
`timescale 1ns/1ns
`default_nettype none
module bb_ctrl_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic go,
  input wire logic if_locked,
  output logic load_strobe,
  output logic transmit_enable
);
  logic [1:0] st_reg;
  logic [3:0] cnt_reg;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg <= 2'h0;
      cnt_reg <= 4'h0;
      load_strobe <= 1'b0;
      transmit_enable <= 1'b0;
    end else if (st_reg == 2'h0 && go) begin
      st_reg <= 2'h1;
      load_strobe <= 1'b1;
      cnt_reg <= 4'h4;
    end else if (st_reg == 2'h2 && if_locked) begin
      st_reg <= 2'h3;
      transmit_enable <= 1'b1;
      cnt_reg <= 4'h6;
    end else if (st_reg[0] && cnt_reg == 4'h1) begin
      st_reg <= st_reg + 2'h1;
      load_strobe <= 1'b0;
      transmit_enable <= 1'b0;
    end else if (st_reg[0]) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule // bb_ctrl_model
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the synthesizer loop control logic
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk_sys = 1'h0, rst = 1'h1, main_loop_enable = 1'h0, go = 1'h0;
  logic aux_loop_enable = 1'h0, alternate_programming_scheme = 1'h0;
  logic main_word_load = 1'h0, ref_div_pulse = 1'h0, test_word_load = 1'h0;
  logic fourth_word_load = 1'h0, main_lock_flag = 1'h0, aux_lock_flag = 1'h0;
  logic if_lock_flag = 1'h0, standby_mode = 1'h0, frac_overflow = 1'h0;
  logic aux_div_out = 1'h0, main_div_out = 1'h0, main_ref_div_out = 1'h0;
  logic [3:0] speedup_length = 4'h0;
  logic [19:0] test_word = 20'h0;
  logic [1:0] if_div_code = 2'h0;
  wire load_strobe, transmit_enable, main_stage_on, aux_stage_on;
  wire ref_chain_on, word_load_ready, speedup_on, integral_pump_on, lock_out;
  wire pump_force_up, pump_force_down, ref_chain_test, frac_pump_test;
  wire main_prescaler_bypass, aux_prescaler_bypass, if_synth_on;
  wire tx_chain_on, free_clock_on, switched_clock_on;
  wire [3:0] if_divide_ratio;
  int n_fail = 0, total_checks = 0, cyc = 0;
  logic [3:0] nd;
  logic [19:0] tws [8] = '{20'hC0000, 20'h40000, 20'h000A8, 20'h00058,
    20'h00200, 20'h00106, 20'h08005, 20'h10007};
  logic [5:0] exv [8] = '{6'h00, 6'h00, 6'h20, 6'h10, 6'h08, 6'h04, 6'h02,
    6'h01};
  synth_loop_control_logic dut (.*);
  bb_ctrl_model bb (.clk_sys, .rst, .go, .if_locked(if_lock_flag),
    .load_strobe, .transmit_enable);
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic put_test(input logic [19:0] w, input logic fourth);
    test_word = w;
    test_word_load = 1'h1;
    fourth_word_load = fourth;
    tick(1);
    test_word_load = 1'h0;
    fourth_word_load = 1'h0;
    tick(1);
  endtask
  function automatic logic exp_lock();
    return (main_lock_flag | ~main_loop_enable) &
      (aux_lock_flag | ~aux_loop_enable);
  endfunction
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h1C6A));
    tick(3);
    rst = 1'h0;
    for (int i = 0; i < 4; i++) begin
      {main_loop_enable, aux_loop_enable} = i[1:0];
      tick(1);
      chk(main_stage_on, main_loop_enable);
      chk(aux_stage_on, aux_loop_enable);
      chk(ref_chain_on, main_loop_enable | aux_loop_enable);
      chk(word_load_ready, 1);
    end
    repeat (12) begin
      {main_loop_enable, aux_loop_enable, main_lock_flag, aux_lock_flag,
        if_lock_flag} = 5'($urandom);
      tick(1);
      chk(lock_out, exp_lock());
    end
    {main_loop_enable, aux_loop_enable} = 2'h2;
    for (int n = 4; n < 8; n++) begin
      put_test({16'h0000, 4'(n)}, 1'h0);
      nd = 4'($urandom);
      {frac_overflow, aux_div_out, main_div_out, main_ref_div_out} = nd;
      tick(1);
      chk(lock_out, nd[7 - n]);
    end
    for (int i = 0; i < 8; i++) begin
      main_lock_flag = i[0];
      put_test(tws[i], 1'h0);
      chk({pump_force_up, pump_force_down, frac_pump_test,
        main_prescaler_bypass, aux_prescaler_bypass, ref_chain_test},
        exv[i]);
      if (i < 2) chk(lock_out, !i[0]);
    end
    put_test(20'h000A8, 1'h0);
    put_test(20'h00000, 1'h0);
    chk(pump_force_up, 0);
    put_test(20'h000A8, 1'h0);
    put_test(20'hC0000, 1'h1);
    chk({pump_force_up, lock_out}, {1'h0, main_lock_flag});
    for (int i = 0; i < 4; i++) begin
      if_div_code = i[1:0];
      standby_mode = 1'($urandom);
      tick(1);
      chk(if_divide_ratio, 4'h6 + i[3:0]);
      chk({free_clock_on, switched_clock_on}, {1'h1, standby_mode});
    end
    standby_mode = 1'h0;
    alternate_programming_scheme = 1'h1;
    for (int k = 0; k < 2; k++) begin
      speedup_length = k ? 4'($urandom) : 4'h0;
      if (k) begin
        main_word_load = 1'h1;
        tick(1);
        main_word_load = 1'h0;
        ref_div_pulse = 1'h1;
        tick(3);
        ref_div_pulse = 1'h0;
      end
      main_word_load = 1'h1;
      tick(1);
      main_word_load = 1'h0;
      tick(2);
      for (int p = 0; p < {speedup_length, 4'hF}; p++) begin
        chk({speedup_on, integral_pump_on}, 2'h3);
        ref_div_pulse = 1'h1;
        tick(1);
        ref_div_pulse = 1'h0;
        tick(1);
      end
      chk(speedup_on, 0);
    end
    alternate_programming_scheme = 1'h0;
    if_lock_flag = 1'h0;
    go = 1'h1;
    tick(1);
    go = 1'h0;
    tick(2);
    chk({load_strobe, speedup_on}, 2'h3);
    for (int k = 0; k < 20 && load_strobe; k++) tick(1);
    tick(2);
    chk({speedup_on, if_synth_on, lock_out}, 3'h2);
    standby_mode = 1'h1;
    tick(1);
    chk(lock_out, 1);
    standby_mode = 1'h0;
    if_lock_flag = 1'h1;
    for (int k = 0; k < 20 && !transmit_enable; k++) tick(1);
    tick(2);
    chk({if_synth_on, tx_chain_on}, 2'h3);
    chk(switched_clock_on, 1);
    for (int k = 0; k < 20 && transmit_enable; k++) tick(1);
    tick(4);
    chk({if_synth_on, tx_chain_on}, 2'h0);
    chk(switched_clock_on, 0);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
